//--- rtl/fms_regs.svh
`ifndef FMS_REGS_SVH
`define FMS_REGS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses on the apb bus)
// ----------------------------------------------------------------
`define FMS_A_CTRL 8'h00
`define FMS_A_STATUS 8'h04
`define FMS_A_IRQ_STAT 8'h08
`define FMS_A_IRQ_MASK 8'h0C
`define FMS_A_SLV_CFG 8'h10
`define FMS_A_NODE 8'h14
`define FMS_A_FAIL_LO 8'h18
`define FMS_A_FAIL_HI 8'h1C
`define FMS_A_EXCL_LO 8'h20
`define FMS_A_EXCL_HI 8'h24
`define FMS_A_POINTS 8'h28
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FMS_CTRL_GO 0
`define FMS_CTRL_STROBE 1
`define FMS_CTRL_CLEAR 2
`define FMS_CTRL_RATE_LSB 4
`define FMS_RST_RATE 2'h0
`define FMS_RST_NODE 6'h00
`define FMS_RST_MASK 10'h000
`define FMS_EV_DUP 0
`define FMS_EV_FAIL 1
`define FMS_EV_PARAM 2
`define FMS_EV_TMO 3
`define FMS_EV_CAN_LSB 4
`define FMS_EV_BUSOFF 9
// ----------------------------------------------------------------
// timing in its own unit, plus the clock rate
// ----------------------------------------------------------------
`define FMS_CLK_HZ 20000000
`define FMS_DUP_WIN_MS 2
`define FMS_HB_MS 1000
`define FMS_FLASH_MS 250
`endif

//--- rtl/fms_pkg.sv
package fms_pkg;
  // supervision sequence
  typedef enum logic [2:0] {
    ST_START = 3'b000,
    ST_DUPCHK = 3'b001,
    ST_ONLINE = 3'b010,
    ST_HBCHK = 3'b011,
    ST_DUPFAIL = 3'b100
  } fms_state_t;
  // data transfer type per slave
  typedef enum logic [1:0] {
    XF_POLL = 2'b00,
    XF_STROBE = 2'b01,
    XF_CYCLIC = 2'b10,
    XF_COS = 2'b11
  } fms_xfer_t;
  // fault flags from the can frame engine
  typedef struct packed {
    logic crc;
    logic form;
    logic ack;
    logic bitmon;
    logic stuff;
  } fms_can_err_t;
  // slave configuration word
  typedef struct packed {
    logic en;
    logic [4:0] rsv;
    logic [8:0] out_len;
    logic [8:0] in_len;
    logic [1:0] xtype;
    logic [5:0] addr;
  } fms_slv_cfg_t;
  // indicator lamps
  typedef struct packed {
    logic ready;
    logic run;
    logic net_green;
    logic net_red;
  } fms_led_t;
  // service request toward the exchange engine
  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [1:0] xtype;
    logic frag_in;
    logic frag_out;
  } fms_serve_t;
endpackage : fms_pkg

//--- rtl/fms_supervisor.sv
// Functional notes
// - check duplicate node address before data exchange
// - at most 256 input, 256 output bytes
// - total io points never above 57344
// - bit rate only 125, 250, 500 kbit/s
// - above 8 data bytes means fragmented
// - detect crc, form, ack, bit, stuff faults
// - slaves with bad parameters are excluded
// - failed slave recorded, others still served
// - duplicate check repeated as heartbeat
// - up to 64 nodes including master
// - polled, strobe, cyclic, change-of-state transfers
// - bit-strobe message synchronises slave io
// - ready lamp encodes boot, error, defect
// - run lamp encodes communication state
// - steady green when online with connection
// - green flash when online, no connection
// - steady red on duplicate address, bus off
// - off during check, red flash, alternating (here off only in the start-up check, not the heartbeat check)
//
// Local design decisions: the register addresses and the APB register port.
`include "fms_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fms_supervisor
  import fms_pkg::*;
#(
  parameter int NODES = 64,
  parameter int MAX_BYTES = 256,
  parameter int MAX_POINTS = 57344,
  parameter int FRAME_BYTES = 8,
  parameter int DUP_WIN_CYC = `FMS_DUP_WIN_MS * (`FMS_CLK_HZ / 1000),
  parameter int HB_CYC = `FMS_HB_MS * (`FMS_CLK_HZ / 1000),
  parameter int FLASH_CYC = `FMS_FLASH_MS * (`FMS_CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can frame engine events
  input wire fms_can_err_t can_err,
  input wire logic bus_off,
  input wire logic dup_seen,
  input wire logic resp_valid,
  input wire logic [5:0] resp_id,
  input wire logic slave_timeout,
  input wire logic [5:0] timeout_id,
  // platform health
  input wire logic boot_active,
  input wire logic hw_fault,
  input wire logic hw_defect,
  // requests toward the frame engine
  output logic dup_req,
  output logic strobe_req,
  output logic [1:0] bit_rate,
  output fms_serve_t serve,
  input wire logic serve_ready,
  // indicators and interrupt
  output fms_led_t led,
  output logic irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NODES != 64 || MAX_BYTES > 256 || MAX_BYTES < 1 ||
      MAX_POINTS > 65535 || DUP_WIN_CYC < 2 || HB_CYC < 2 ||
      FLASH_CYC < 2) begin : g_bad_param
    $error("fms_supervisor: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fms_state_t st;
    logic go;
    logic [31:0] timer;
    logic [31:0] hb;
    logic [31:0] flash;
    logic phase;
    logic [2:0] pat;
    logic [63:0] active;
    logic [63:0] excl;
    logic [63:0] failed;
    logic [63:0] seen;
    logic [63:0] frag_in;
    logic [63:0] frag_out;
    logic [127:0] xtype;
    logic [16:0] points;
    logic [5:0] ptr;
    fms_serve_t serve;
    logic dup_req;
    logic strobe_req;
    logic [1:0] rate;
    logic [5:0] node;
    logic [9:0] irq_stat;
    logic [9:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fms_led_t led;
    logic irq;
  } fms_regs_t;

  fms_regs_t s;
  fms_regs_t next_s;

  localparam logic [7:0] PATTERN = 8'hD2; // irregular on/off run
  localparam logic [1:0] RATE_BAD = 2'h3;

  // io points of one slave: eight per byte in both directions
  function automatic logic [16:0] slave_points(logic [8:0] i,
                                               logic [8:0] o);
    slave_points = 17'((17'(i) + 17'(o)) << 3);
  endfunction : slave_points

  // one word of a 64-bit vector for the bus
  function automatic logic [31:0] half(logic [63:0] v, logic hi);
    half = hi ? v[63:32] : v[31:0];
  endfunction : half

  logic acc;
  logic commit;
  logic wr;
  logic [9:0] ev;
  logic [9:0] clr;
  logic [63:0] elig;
  logic conn;
  logic flash_tick;
  logic noncyc;
  fms_slv_cfg_t cfg;
  logic cfg_ok;
  logic [16:0] cfg_pts;
  logic [31:0] rd;
  logic rd_ok;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.dup_req = 1'b0;
    next_s.strobe_req = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    ev = '0;
    clr = '0;
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    // access phase answered one cycle after it opens
    acc = psel && penable && !s.pready;
    commit = psel && penable && s.pready;
    wr = commit && pwrite;
    cfg = fms_slv_cfg_t'(pwdata);
    cfg_pts = slave_points(cfg.in_len, cfg.out_len);
    cfg_ok = cfg.in_len <= 9'(MAX_BYTES) &&
             cfg.out_len <= 9'(MAX_BYTES) &&
             cfg.addr != s.node &&
             (s.points + cfg_pts) <= 17'(MAX_POINTS);
    elig = s.active & ~s.failed & ~s.excl;
    conn = |elig;

    // read mux, prepared while the access is held
    case (paddr)
      `FMS_A_CTRL: rd = {26'h0, s.rate, 3'h0, s.go};
      `FMS_A_STATUS: rd = {28'h0, conn, s.st};
      `FMS_A_IRQ_STAT: rd = {22'h0, s.irq_stat};
      `FMS_A_IRQ_MASK: rd = {22'h0, s.irq_mask};
      `FMS_A_SLV_CFG: rd = 32'h0000_0000;
      `FMS_A_NODE: rd = {26'h0, s.node};
      `FMS_A_FAIL_LO: rd = half(s.failed, 1'b0);
      `FMS_A_FAIL_HI: rd = half(s.failed, 1'b1);
      `FMS_A_EXCL_LO: rd = half(s.excl, 1'b0);
      `FMS_A_EXCL_HI: rd = half(s.excl, 1'b1);
      `FMS_A_POINTS: rd = {15'h0, s.points};
      default: rd_ok = 1'b0;
    endcase
    if (acc) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !rd_ok;
      next_s.prdata = rd_ok ? rd : 32'h0000_0000;
    end

    // register writes take effect on the completing edge
    if (wr && rd_ok) begin
      case (paddr)
        `FMS_A_CTRL: begin
          next_s.go = pwdata[`FMS_CTRL_GO];
          next_s.strobe_req = pwdata[`FMS_CTRL_STROBE];
          // the rate can only change while the master is idle
          if (s.st == ST_START &&
              pwdata[`FMS_CTRL_RATE_LSB+:2] != RATE_BAD) begin
            next_s.rate = pwdata[`FMS_CTRL_RATE_LSB+:2];
          end
          if (pwdata[`FMS_CTRL_CLEAR]) begin
            next_s.active = '0;
            next_s.excl = '0;
            next_s.failed = '0;
            next_s.points = '0;
          end
        end
        `FMS_A_IRQ_STAT: clr = pwdata[9:0];
        `FMS_A_IRQ_MASK: next_s.irq_mask = pwdata[9:0];
        `FMS_A_NODE: next_s.node = pwdata[5:0];
        `FMS_A_SLV_CFG: begin
          if (!cfg.en) begin
            next_s.active[cfg.addr] = 1'b0;
          end else if (cfg_ok) begin
            next_s.active[cfg.addr] = 1'b1;
            next_s.excl[cfg.addr] = 1'b0;
            next_s.failed[cfg.addr] = 1'b0;
            next_s.xtype[2*cfg.addr+:2] = cfg.xtype;
            next_s.frag_in[cfg.addr] =
              cfg.in_len > 9'(FRAME_BYTES);
            next_s.frag_out[cfg.addr] =
              cfg.out_len > 9'(FRAME_BYTES);
            next_s.points = s.points + cfg_pts;
          end else begin
            // bad parameters keep the slave out of cyclic exchange
            next_s.active[cfg.addr] = 1'b0;
            next_s.excl[cfg.addr] = 1'b1;
            ev[`FMS_EV_PARAM] = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // slave answers during a check; a returning slave rejoins
    if (resp_valid) begin
      next_s.seen[resp_id] = 1'b1;
      next_s.failed[resp_id] = 1'b0;
    end
    // a failure after the answer wins in the same cycle
    if (slave_timeout && s.active[timeout_id]) begin
      next_s.failed[timeout_id] = 1'b1;
      ev[`FMS_EV_FAIL] = 1'b1;
      ev[`FMS_EV_TMO] = 1'b1;
    end
    ev[`FMS_EV_CAN_LSB+:5] = can_err;
    ev[`FMS_EV_BUSOFF] = bus_off;

    // supervision sequence
    case (s.st)
      ST_START: begin
        if (s.go) begin
          next_s.st = ST_DUPCHK;
          next_s.dup_req = 1'b1;
          next_s.timer = '0;
          next_s.seen = '0;
        end
      end
      ST_DUPCHK, ST_HBCHK: begin
        next_s.timer = s.timer + 32'd1;
        if (dup_seen) begin
          next_s.st = ST_DUPFAIL;
          ev[`FMS_EV_DUP] = 1'b1;
        end else if (s.timer == 32'(DUP_WIN_CYC - 1)) begin
          next_s.st = ST_ONLINE;
          next_s.hb = '0;
          // silent slaves in a heartbeat round count as failed
          if (s.st == ST_HBCHK && (elig & ~s.seen) != '0) begin
            next_s.failed = next_s.failed |
                            (elig & ~s.seen);
            ev[`FMS_EV_FAIL] = 1'b1;
          end
        end
      end
      ST_ONLINE: begin
        next_s.hb = s.hb + 32'd1;
        if (s.hb == 32'(HB_CYC - 1)) begin
          next_s.st = ST_HBCHK;
          next_s.dup_req = 1'b1;
          next_s.timer = '0;
          next_s.seen = '0;
        end
      end
      ST_DUPFAIL: ; // held until software drops go
      default: next_s.st = ST_START;
    endcase
    if (!s.go) begin
      next_s.st = ST_START;
    end

    // round robin service, failed and excluded slots skipped
    if (s.serve.valid) begin
      if (serve_ready) begin
        next_s.serve.valid = 1'b0;
      end
    end else if (s.st == ST_ONLINE || s.st == ST_HBCHK) begin
      next_s.ptr = s.ptr + 6'd1;
      if (elig[s.ptr]) begin
        next_s.serve.valid = 1'b1;
        next_s.serve.addr = s.ptr;
        next_s.serve.xtype = s.xtype[2*s.ptr+:2];
        next_s.serve.frag_in = s.frag_in[s.ptr];
        next_s.serve.frag_out = s.frag_out[s.ptr];
      end
    end

    // sticky events, set wins over a write-one clear
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

    // flash timebase: even halves, plus an irregular pattern
    flash_tick = s.flash == 32'(FLASH_CYC - 1);
    next_s.flash = flash_tick ? 32'd0 : s.flash + 32'd1;
    if (flash_tick) begin
      next_s.phase = !s.phase;
      next_s.pat = s.pat + 3'd1;
    end
    noncyc = PATTERN[s.pat];

    // ready lamp
    if (hw_defect) begin
      next_s.led.ready = 1'b0;
    end else if (hw_fault) begin
      next_s.led.ready = noncyc;
    end else if (boot_active) begin
      next_s.led.ready = s.phase;
    end else begin
      next_s.led.ready = 1'b1;
    end

    // run lamp
    if (s.irq_stat[`FMS_EV_PARAM]) begin
      next_s.led.run = noncyc;
    end else if (s.st == ST_ONLINE || s.st == ST_HBCHK) begin
      next_s.led.run = conn ? 1'b1 : s.phase;
    end else begin
      next_s.led.run = 1'b0;
    end

    // network/module lamp, most severe condition first
    if (s.st == ST_DUPFAIL || bus_off) begin
      next_s.led.net_green = 1'b0;
      next_s.led.net_red = 1'b1;
    end else if (s.st == ST_START || s.st == ST_DUPCHK) begin
      next_s.led.net_green = 1'b0;
      next_s.led.net_red = 1'b0;
    end else if (s.irq_stat[`FMS_EV_TMO]) begin
      next_s.led.net_green = 1'b0;
      next_s.led.net_red = s.phase;
    end else if (|s.irq_stat[`FMS_EV_CAN_LSB+:5]) begin
      next_s.led.net_green = s.phase;
      next_s.led.net_red = !s.phase;
    end else if (conn) begin
      next_s.led.net_green = 1'b1;
      next_s.led.net_red = 1'b0;
    end else begin
      next_s.led.net_green = s.phase;
      next_s.led.net_red = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_START;
      s.rate <= `FMS_RST_RATE;
      s.node <= `FMS_RST_NODE;
      s.irq_mask <= `FMS_RST_MASK;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign dup_req = s.dup_req;
  assign strobe_req = s.strobe_req;
  assign bit_rate = s.rate;
  assign serve = s.serve;
  assign led = s.led;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_DUP_BEFORE_ONLINE: assert property (
    s.st == ST_START |=> s.st inside {ST_START, ST_DUPCHK})
    else $error("online reached without duplicate check");

  AST_BYTES_EXCLUDED: assert property (
    (psel && penable && s.pready && pwrite &&
     paddr == `FMS_A_SLV_CFG && pwdata[31] &&
     pwdata[16:8] > 9'(MAX_BYTES)) |=> s.excl[$past(pwdata[5:0])])
    else $error("oversized slave not excluded");

  AST_POINTS_LIMIT: assert property (
    s.points <= 17'(MAX_POINTS))
    else $error("io point total above limit");

  AST_RATE_LEGAL: assert property (
    s.rate != RATE_BAD)
    else $error("illegal bit rate code");

  AST_FAIL_RECORDED: assert property (
    (slave_timeout && s.active[timeout_id]) |=>
      s.failed[$past(timeout_id)] && s.irq_stat[`FMS_EV_FAIL])
    else $error("slave failure not recorded");

  AST_HEARTBEAT_START: assert property (
    (s.go && s.st == ST_ONLINE && s.hb == 32'(HB_CYC - 1)) |=>
      s.st == ST_HBCHK && s.dup_req)
    else $error("heartbeat check not started");

  AST_STROBE_ISSUED: assert property (
    (psel && penable && s.pready && pwrite &&
     paddr == `FMS_A_CTRL && pwdata[`FMS_CTRL_STROBE]) |=>
      s.strobe_req ##1 !s.strobe_req)
    else $error("bit strobe request missing");

  AST_READY_DEFECT: assert property (
    hw_defect |=> !s.led.ready)
    else $error("ready lamp lit with defective hardware");

  AST_NET_OFF_CHECK: assert property (
    (s.st == ST_DUPCHK && $past(s.st) == ST_DUPCHK && !bus_off &&
     !$past(bus_off)) |-> !s.led.net_green && !s.led.net_red)
    else $error("network lamp lit during duplicate check");

  AST_NET_RED_DUP: assert property (
    (s.go && s.st == ST_DUPCHK && dup_seen) |=> ##1
      (s.led.net_red && !s.led.net_green) [*2])
    else $error("duplicate address not shown steady red");

endmodule : fms_supervisor
`default_nettype wire

//--- tb/fms_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side slaves behind the frame engine
// ----------------------------------------
module fms_slave_model
  import fms_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // scenario controls
  input wire logic [63:0] present,
  input wire logic [63:0] mute,
  input wire logic dup_on,
  input wire logic slow,
  // master side
  input wire logic dup_req,
  input wire fms_serve_t serve,
  output logic serve_ready,
  output logic dup_seen,
  output logic resp_valid,
  output logic [5:0] resp_id
);
  logic [6:0] scan;
  logic [1:0] lag;
  logic [5:0] junk;
  // after a check every id gets one cycle; a clash answers at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan <= 7'h40;
      junk <= 6'h00;
      dup_seen <= 1'b0;
    end else begin
      junk <= junk + 6'h25;
      scan <= dup_req ? 7'h00 : scan + {6'h00, ~scan[6]};
      dup_seen <= dup_req & dup_on;
    end
  end
  // muted ids stay silent; idle id changes each cycle so it is never trusted
  assign resp_valid = ~scan[6] & present[scan[5:0]] & ~mute[scan[5:0]];
  assign resp_id = resp_valid ? scan[5:0] : junk;
  // ready at once, or after a stall when slow
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serve_ready <= 1'b0;
      lag <= 2'h0;
    end else if (serve.valid && !serve_ready && (!slow || lag == 2'h3)) begin
      serve_ready <= 1'b1;
    end else begin
      serve_ready <= 1'b0;
      lag <= (serve.valid && !serve_ready) ? lag + 2'h1 : 2'h0;
    end
  end
endmodule : fms_slave_model
`default_nettype wire

//--- tb/tb_fieldbus_master_status_supervision.sv
`include "fms_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_master_status_supervision
  import fms_pkg::*;
;
  // ----------------------------------------
  // signals, design and far side
  // ----------------------------------------
  localparam int DUPW = 40;
  localparam int HBC = 200;
  localparam int FLC = 8;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, clr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  fms_can_err_t can_err;
  logic bus_off, dup_seen, resp_valid, slave_timeout, serve_ready;
  logic [5:0] resp_id, timeout_id;
  logic boot_active, hw_fault, hw_defect, dup_req, strobe_req;
  logic [1:0] bit_rate;
  fms_serve_t serve;
  fms_led_t led;
  logic [63:0] present, mute, seen;
  logic dup_on, slow;
  logic [3:0] xt [64];
  int n_mismatch, tests_run, n_dup, n_strobe, cyc;
  fms_supervisor #(.DUP_WIN_CYC(DUPW), .HB_CYC(HBC), .FLASH_CYC(FLC)) dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .can_err, .bus_off, .dup_seen, .resp_valid, .resp_id,
    .slave_timeout, .timeout_id, .boot_active, .hw_fault, .hw_defect,
    .dup_req, .strobe_req, .bit_rate, .serve, .serve_ready, .led, .irq);
  fms_slave_model far (.clk, .rst, .present, .mute, .dup_on, .slow,
    .dup_req, .serve, .serve_ready, .dup_seen, .resp_valid, .resp_id);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count pulses, record served slots, cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_dup <= n_dup + int'(dup_req === 1'b1);
    n_strobe <= n_strobe + int'(strobe_req === 1'b1);
    if (clr) begin
      seen <= '0;
    end else if (serve.valid === 1'b1 && serve_ready) begin
      seen[serve.addr] <= 1'b1;
      xt[serve.addr] <= {serve.xtype, serve.frag_in, serve.frag_out};
    end
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one apb transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // lamp on-counts over two flash periods
  task automatic lamp(output int g, output int r, output int y);
    g = 0;
    r = 0;
    y = 0;
    repeat (4 * FLC) begin
      @(posedge clk);
      g += int'(led.net_green === 1'b1);
      r += int'(led.net_red === 1'b1);
      y += int'(led.ready === 1'b1);
    end
  endtask : lamp
  // only the start-up check darkens the network lamp; still sample after a heartbeat check
  task automatic after_hb;
    int nd;
    nd = n_dup;
    while (n_dup == nd) @(posedge clk);
    tick(DUPW + 6);
  endtask : after_hb
  function automatic logic [31:0] cfg(int a, int t, int il, int ol);
    return {1'b1, 5'h00, ol[8:0], il[8:0], t[1:0], a[5:0]};
  endfunction : cfg
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_setup;
    logic [31:0] q;
    logic e;
    chk({led, irq, dup_req}, 0, "outputs after reset");
    apb(1'b0, 8'h3C, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000, "unmapped read");
    for (int r = 0; r < 4; r++) begin
      wr(`FMS_A_CTRL, 32'(r) << 4);
      tick(2);
      chk(bit_rate, (r < 3) ? r : 2, "rate code");
    end
    wr(`FMS_A_NODE, 32'h5);
    for (int i = 0; i < 15; i++) wr(`FMS_A_SLV_CFG, cfg(10 + i, 2, 256, 256));
    rd(`FMS_A_POINTS, q);
    chk(q, 57344, "full point budget");
    rd(`FMS_A_EXCL_LO, q);
    chk(q[24:23], 2'b10, "slave over budget");
    wr(`FMS_A_CTRL, 32'h24);
    rd(`FMS_A_POINTS, q);
    chk(q, 0, "table cleared");
    wr(`FMS_A_IRQ_STAT, 32'h3FF);
    wr(`FMS_A_SLV_CFG, cfg(1, 0, 16, 8));
    wr(`FMS_A_SLV_CFG, cfg(2, 1, 4, 4));
    wr(`FMS_A_SLV_CFG, cfg(3, 2, 256, 256));
    wr(`FMS_A_SLV_CFG, cfg(4, 3, 1, 1));
    wr(`FMS_A_SLV_CFG, cfg(6, 0, 257, 1));
    wr(`FMS_A_SLV_CFG, cfg(5, 0, 1, 1));
    rd(`FMS_A_POINTS, q);
    chk(q, 4368, "points of accepted slaves");
    rd(`FMS_A_EXCL_LO, q);
    chk(q & 32'h7E, 32'h60, "bad slaves excluded");
    rd(`FMS_A_IRQ_STAT, q);
    chk(q[2], 1'b1, "parameter event");
    $display("test setup done");
  endtask : t_setup
  task automatic t_online;
    logic [31:0] q;
    int nd, g, r, y;
    nd = n_dup;
    wr(`FMS_A_CTRL, 32'h21);
    tick(3);
    chk(n_dup - nd, 1, "check sent at go");
    rd(`FMS_A_STATUS, q);
    chk(q[2:0], ST_DUPCHK, "checking");
    chk({led.net_green, led.net_red}, 0, "dark in check");
    clr <= 1'b1;
    tick(DUPW);
    clr <= 1'b0;
    rd(`FMS_A_STATUS, q);
    chk(q[2:0], ST_ONLINE, "online after check");
    tick(60);
    lamp(g, r, y);
    chk(q[3], 1'b1, "connection flag");
    chk({g, r}, {32'd32, 32'd0}, "green lamp");
    chk(y, 32, "ready lamp");
    chk(seen, 64'h1E, "served slots");
    chk({xt[1], xt[2], xt[3], xt[4]}, 16'h24BC, "types, fragments");
    $display("test online done");
  endtask : t_online
  task automatic t_heart;
    logic [31:0] q;
    int nd;
    mute <= 64'h4;
    slow <= 1'b1;
    nd = n_dup;
    while (n_dup == nd) @(posedge clk);
    rd(`FMS_A_STATUS, q);
    chk(q[2:0], ST_HBCHK, "heartbeat check");
    tick(DUPW);
    rd(`FMS_A_FAIL_LO, q);
    chk(q[7:0], 8'h04, "silent slave failed");
    rd(`FMS_A_IRQ_STAT, q);
    chk(q[1], 1'b1, "failure event");
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(100);
    chk({seen[4:3], seen[1]}, 3'b111, "others still served");
    $display("test heartbeat done");
  endtask : t_heart
  task automatic t_faults;
    logic [31:0] q;
    int g, r, y;
    wr(`FMS_A_IRQ_STAT, 32'h3FF);
    wr(`FMS_A_IRQ_MASK, 32'h3F0);
    chk(led.run, 1'b1, "run lamp on");
    for (int i = 0; i < 5; i++) begin
      can_err <= 5'(1 << i);
      tick(1);
      can_err <= '0;
      tick(3);
      chk(irq, 1'b1, "fault raises irq");
      rd(`FMS_A_IRQ_STAT, q);
      chk(q & 32'h3F0, 32'h10 << i, "fault bit");
      wr(`FMS_A_IRQ_STAT, 32'h10 << i);
      tick(2);
      chk(irq, 1'b0, "irq after clear");
    end
    wr(`FMS_A_IRQ_MASK, 32'h0);
    can_err <= 5'h01;
    tick(1);
    can_err <= '0;
    tick(3);
    chk(irq, 1'b0, "masked fault");
    after_hb;
    slave_timeout <= 1'b1;
    timeout_id <= 6'h3;
    tick(1);
    slave_timeout <= 1'b0;
    tick(3);
    lamp(g, r, y);
    chk({g, r}, {32'd0, 32'd16}, "red flash on timeout");
    bus_off <= 1'b1;
    tick(4);
    lamp(g, r, y);
    chk({g, r}, {32'd0, 32'd32}, "steady red bus off");
    bus_off <= 1'b0;
    rd(`FMS_A_IRQ_STAT, q);
    chk(q[9] & q[3], 1'b1, "timeout, bus off events");
    $display("test faults done");
  endtask : t_faults
  task automatic t_lamps;
    int ns, g, r, y, run, mx;
    logic prev;
    ns = n_strobe;
    wr(`FMS_A_CTRL, 32'h23);
    tick(3);
    chk(n_strobe - ns, 1, "strobe message");
    boot_active <= 1'b1;
    tick(3);
    lamp(g, r, y);
    chk(y, 16, "ready flash in boot");
    boot_active <= 1'b0;
    hw_fault <= 1'b1;
    tick(3);
    // an even flash never holds a level past one half period
    {run, mx} = '0;
    prev = led.ready;
    repeat (10 * FLC) begin
      @(posedge clk);
      run = (led.ready === prev) ? run + 1 : 1;
      prev = led.ready;
      mx = (run > mx) ? run : mx;
    end
    chk(mx > FLC && mx < 10 * FLC, 1'b1, "uneven ready");
    hw_fault <= 1'b0;
    hw_defect <= 1'b1;
    tick(3);
    lamp(g, r, y);
    chk(y, 0, "ready dark on defect");
    hw_defect <= 1'b0;
    $display("test lamps done");
  endtask : t_lamps
  task automatic t_dup;
    logic [31:0] q;
    int g, r, y;
    // empty table: online without any connection
    wr(`FMS_A_CTRL, 32'h24);
    wr(`FMS_A_IRQ_STAT, 32'h3FF);
    wr(`FMS_A_CTRL, 32'h21);
    tick(DUPW + 4);
    lamp(g, r, y);
    chk({g, r}, {32'd16, 32'd0}, "green flash");
    wr(`FMS_A_CTRL, 32'h20);
    wr(`FMS_A_SLV_CFG, cfg(1, 0, 1, 1));
    dup_on <= 1'b1;
    wr(`FMS_A_CTRL, 32'h21);
    tick(DUPW);
    rd(`FMS_A_STATUS, q);
    chk(q[2:0], ST_DUPFAIL, "clash stops start");
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    lamp(g, r, y);
    chk({g, r}, {32'd0, 32'd32}, "steady red on clash");
    chk(led.run, 1'b0, "run dark after clash");
    chk(seen, 0, "no exchange after clash");
    $display("test clash done");
  endtask : t_dup
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, clr} = 2'b11;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {can_err, bus_off, slave_timeout, timeout_id} = '0;
    {boot_active, hw_fault, hw_defect, dup_on, slow} = '0;
    present = 64'h1E;
    mute = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    @(posedge clk);
    t_setup;
    t_online;
    t_heart;
    t_faults;
    t_lamps;
    t_dup;
    complete_run;
  end
endmodule : tb_fieldbus_master_status_supervision
`default_nettype wire
